// ### bench/pmc_partner.sv
// Model of the power-state source and the emulating power stage
`timescale 1ns/1ps
module pmc_partner (
	input  wire logic          ref_clk,
	input  wire logic [1:0]    ps_cmd,
	input  wire logic [3:0]    diode_n,
	output logic               cycle_start,
	output logic               power_state_low0_n,
	output logic               power_state_low1_n,
	output pmc_pkg::pmc_zc_in_t zc
);
	logic [4:0] cnt_q = 5'h00;
	logic [1:0] ps_q  = 2'h3;

	// Pins move mid-cycle, far from the boundary pulse
	always @(posedge ref_clk) begin
		cnt_q <= cnt_q + 5'h01;
		if (cnt_q == 5'h10)
			ps_q <= ps_cmd;
	end

	assign cycle_start        = (cnt_q == 5'h00);
	assign power_state_low1_n = ps_q[1];
	assign power_state_low0_n = ps_q[0];
	assign zc.ls_on           = (cnt_q >= 5'h08) && (cnt_q <= 5'h0b);
	assign zc.zc_cmp          = (cnt_q == 5'h0b);
	// Body diode conducts for diode_n cycles after low side turns off
	assign zc.body_diode      = (cnt_q >= 5'h0c) &&
		(cnt_q < 5'h0c + 5'(diode_n));
	assign zc.reverse_spike   = 1'b0;
endmodule : pmc_partner

// ### bench/pmc_phase_mode_controller_tb.sv
// Self-checking bench of the phase and mode controller
`timescale 1ns/1ps
module pmc_phase_mode_controller_tb;
	localparam logic [11:0] CS_T = 12'b100_011_001_000;
	localparam logic [7:0]  AS_T = 8'b00_10_01_00;
	localparam logic [11:0] CE_T = 12'b000_001_011_111;
	localparam logic [11:0] AE_T = 12'b011_000_001_011;

	logic                   ref_clk = 1'b0;
	logic                   rst     = 1'b1;
	logic [2:0]             cs      = 3'h0;
	logic [1:0]             as      = 2'h0;
	logic [1:0]             ps_cmd  = 2'h3;
	logic [3:0]             diode_n = 4'h8;
	logic [7:0]             mon_c   = 8'h00;
	logic [7:0]             mon_a   = 8'h00;
	pmc_pkg::pmc_bus_req_t  bus_req = '0;
	logic                   cycle_start;
	logic                   pl0;
	logic                   pl1;
	pmc_pkg::pmc_zc_in_t    zc;
	logic [15:0]            rd_data_q;
	pmc_pkg::pmc_rail_out_t co;
	pmc_pkg::pmc_rail_out_t ao;
	logic                   sw;
	logic                   oe;
	int                     num_errors = 0;
	int                     tests_run  = 0;
	logic [15:0]            v;

	always #2.5 ref_clk = ~ref_clk;

	pmc_partner u_pmc_partner (.ref_clk(ref_clk), .ps_cmd(ps_cmd),
		.diode_n(diode_n), .cycle_start(cycle_start),
		.power_state_low0_n(pl0), .power_state_low1_n(pl1), .zc(zc));

	pmc_phase_mode_controller u_pmc_phase_mode_controller (
		.ref_clk(ref_clk), .rst(rst), .core_phase1_sense(cs[2]),
		.core_phase2_sense(cs[1]), .core_phase3_sense(cs[0]),
		.aux_rail_phase1_sense(as[1]), .aux_rail_phase2_sense(as[0]),
		.power_state_low0_n(pl0), .power_state_low1_n(pl1),
		.cycle_start(cycle_start), .core_current_monitor(mon_c),
		.aux_rail_current_monitor(mon_a), .core_zc(zc), .aux_zc(zc),
		.bus_req(bus_req), .rd_data_q(rd_data_q), .core_out_q(co),
		.aux_out_q(ao), .comp_switch_closed_q(sw),
		.aux_comp_cap_node_oe_q(oe));

	task finish_test;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test

	task chk(input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR %0t seen %h exp %h", $time, s, e);
		end
	endtask : chk

	task tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick

	task wr(input logic [3:0] a, input logic [15:0] d);
		bus_req <= '{a, d, 1'b1, 1'b0};
		tick(1);
		bus_req <= '0;
		tick(1);
	endtask : wr

	task rd(input logic [3:0] a, output logic [15:0] d);
		bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
		tick(1);
		bus_req <= '0;
		d = rd_data_q;
		tick(1);
	endtask : rd

	// Bounded wait for a low-side level
	task wt(input logic l);
		int n;
		n = 0;
		while (zc.ls_on !== l) begin
			tick(1);
			n++;
			if (n > 64) begin
				num_errors++;
				finish_test();
			end
		end
	endtask : wt

	task do_reset(input logic [2:0] c, input logic [1:0] a);
		cs  <= c;
		as  <= a;
		rst <= 1'b1;
		tick(6);
		rst <= 1'b0;
		tick(4);
	endtask : do_reset

	task t_modes;
		logic [2:0] ce;
		logic [2:0] ae;
		for (int i = 0; i < 4; i++) begin
			do_reset(CS_T[i*3+:3], AS_T[i*2+:2]);
			ps_cmd <= 2'b11;
			tick(70);
			ce = CE_T[i*3+:3];
			ae = AE_T[i*3+:3];
			chk({co.phase_en, ao.phase_en}, {ce, ae});
			chk({co.continuous_conduction, ao.continuous_conduction,
				co.diode_emulation, ao.diode_emulation},
				{|ce, |ae, 2'b00});
			chk({sw, oe}, {i == 1, 1'b0});
			// One single bit low, then both low, then the other single bit low
			for (int j = 0; j < 3; j++) begin
				ps_cmd <= (j == 0) ? 2'b10 : (j == 1) ? 2'b00 : 2'b01;
				tick(70);
				chk({co.phase_en, ao.phase_en},
					{2'b00, |ce, 2'b00, |ae});
				chk({co.diode_emulation, ao.diode_emulation},
					{|ce, |ae});
				chk({co.continuous_conduction, ao.continuous_conduction},
					2'b00);
				chk({sw, oe}, {1'b0, i == 1});
			end
		end
		$display("t_modes done");
	endtask : t_modes

	task t_oc;
		do_reset(3'b000, 2'b00);
		// Low power-state left from the mode scan would shed phases
		ps_cmd <= 2'b11;
		rd(pmc_pkg::REG_SLEW_DIV, v);
		chk(v, pmc_pkg::SLEW_DIV_RST);
		rd(pmc_pkg::REG_ZC_THR, v);
		chk(v, {2{pmc_pkg::ZC_THR_RST}});
		rd(4'hf, v);
		chk(v, 16'h0000);
		cs <= 3'b100;
		tick(70);
		chk(co.phase_en, 3'b111);
		cs <= 3'b000;
		mon_c <= pmc_pkg::OC_LIMIT;
		mon_a <= pmc_pkg::OC_LIMIT - 8'h01;
		tick(2);
		chk({co.overcurrent, ao.overcurrent}, 2'b10);
		rd(pmc_pkg::REG_STATUS, v);
		chk(v[9:8], 2'b01);
		mon_c <= pmc_pkg::OC_LIMIT - 8'h01;
		mon_a <= pmc_pkg::OC_LIMIT;
		ps_cmd <= 2'b10;
		tick(70);
		chk({co.overcurrent, ao.overcurrent}, 2'b01);
		$display("t_oc done");
	endtask : t_oc

	task t_slew;
		ps_cmd <= 2'b11;
		tick(70);
		wr(pmc_pkg::REG_SLEW_DIV, 16'h0002);
		wr(pmc_pkg::REG_CORE_VID, 16'h0003);
		chk(co.vref < 8'h02, 1'b1);
		wr(pmc_pkg::REG_AUX_VID, 16'h0003);
		tick(20);
		chk({ao.vref, co.vref}, 16'h0303);
		rd(pmc_pkg::REG_VREF, v);
		chk(v, 16'h0303);
		wr(pmc_pkg::REG_CORE_VID, 16'h0000);
		tick(2);
		chk({co.vref, co.phase_en, co.diode_emulation},
			{8'h00, 3'b001, 1'b1});
		rd(pmc_pkg::REG_STATUS, v);
		chk(v[0], 1'b1);
		tick(210);
		chk({co.phase_en, co.continuous_conduction}, 4'hf);
		$display("t_slew done");
	endtask : t_slew

	task t_zc;
		logic [7:0] t0;
		logic [7:0] e;
		ps_cmd <= 2'b10;
		tick(70);
		wt(0);
		wt(1);
		tick(3);
		chk({ao.ls_off, co.ls_off}, 2'b00);
		tick(1);
		chk({ao.ls_off, co.ls_off}, 2'b11);
		for (int k = 0; k < 3; k++) begin
			diode_n <= (k == 0) ? 4'h3 : (k == 1) ? 4'hc : 4'h8;
			wt(0);
			wt(1);
			wt(0);
			wt(1);
			tick(2);
			t0 = co.zc_thr;
			wt(0);
			wt(1);
			tick(2);
			e = (k == 0) ? t0 + 8'h01 : (k == 1) ? t0 - 8'h01 : t0;
			chk({ao.zc_thr, co.zc_thr}, {e, e});
		end
		$display("t_zc done");
	endtask : t_zc

	initial begin
		t_modes();
		t_oc();
		t_slew();
		t_zc();
		finish_test();
	end
endmodule : pmc_phase_mode_controller_tb

// ### src/pmc_phase_mode_controller.sv
// Phase count, conduction mode, slewing and zero-cross adaptation
// Summary of operation
// - Three-phase core with power-state 11 runs three phases in CONTINUOUS_CONDUCTION.
// - Third core sense strapped high selects two phases, one and two.
// - Third and second core sense high select one phase only.
// - Three-phase core with first bit low drops to phase one in DE.
// - Power-state 00 keeps any enabled core configuration in single-phase DE.
// - Two-phase core: 11 gives two-phase CONTINUOUS_CONDUCTION, first bit low single DE.
// - One-phase core: 11 gives CONTINUOUS_CONDUCTION, first bit low gives DE.
// - First core sense strapped high disables the core rail.
// - Aux rail two-phase: CONTINUOUS_CONDUCTION for 11, single-phase DE for 10, 01 or 00.
// - Aux second sense high: one phase, CONTINUOUS_CONDUCTION for 11, else DE.
// - Aux first sense strapped high disables the aux rail.
// - Overcurrent at a fixed monitor level, independent of mode.
// - New target ramps each rail's reference at the programmed rate.
// - Downward changes are not forced; output decays with the load.
// - Comp-cap switch exists only for a two-phase core strap.
// - Comp-cap switch closed in two-phase mode, open in single phase.
// - While switch is open, aux comp node tracks the feedback node.
// - In DE, low side turns off when the zero comparator trips.
// - Threshold steps after each turn-off towards 40 ns diode time.
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
module pmc_phase_mode_controller (
	input  wire logic                  ref_clk,
	input  wire logic                  rst,
	input  wire logic                  core_phase1_sense,
	input  wire logic                  core_phase2_sense,
	input  wire logic                  core_phase3_sense,
	input  wire logic                  aux_rail_phase1_sense,
	input  wire logic                  aux_rail_phase2_sense,
	input  wire logic                  power_state_low0_n,
	input  wire logic                  power_state_low1_n,
	input  wire logic                  cycle_start,
	input  wire logic [7:0]            core_current_monitor,
	input  wire logic [7:0]            aux_rail_current_monitor,
	input  wire pmc_pkg::pmc_zc_in_t   core_zc,
	input  wire pmc_pkg::pmc_zc_in_t   aux_zc,
	input  wire pmc_pkg::pmc_bus_req_t bus_req,
	output logic [15:0]                rd_data_q,
	output pmc_pkg::pmc_rail_out_t     core_out_q,
	output pmc_pkg::pmc_rail_out_t     aux_out_q,
	output logic                       comp_switch_closed_q,
	output logic                       aux_comp_cap_node_oe_q
);

	pmc_pkg::pmc_state_t s_q;
	pmc_pkg::pmc_state_t s_d;

	function automatic pmc_pkg::pmc_cfg_t core_strap(
		input logic p1,
		input logic p2,
		input logic p3
	);
		if (p1)
			return pmc_pkg::PMC_CFG_OFF;
		else if (p3 && p2)
			return pmc_pkg::PMC_CFG_1P;
		else if (p3)
			return pmc_pkg::PMC_CFG_2P;
		else
			return pmc_pkg::PMC_CFG_3P;
	endfunction : core_strap

	function automatic pmc_pkg::pmc_cfg_t aux_strap(
		input logic p1,
		input logic p2
	);
		if (p1)
			return pmc_pkg::PMC_CFG_OFF;
		else if (p2)
			return pmc_pkg::PMC_CFG_1P;
		else
			return pmc_pkg::PMC_CFG_2P;
	endfunction : aux_strap

	// Any power-state other than 11 means single-phase DE
	function automatic pmc_pkg::pmc_mode_t rail_mode(
		input pmc_pkg::pmc_cfg_t cfg,
		input logic [1:0]        ps,
		input logic              decaying
	);
		if (cfg == pmc_pkg::PMC_CFG_OFF)
			return pmc_pkg::PMC_MODE_OFF;
		else if (ps != 2'h3 || decaying)
			return pmc_pkg::PMC_MODE_1DE;
		else if (cfg == pmc_pkg::PMC_CFG_1P)
			return pmc_pkg::PMC_MODE_1CCM;
		else
			return pmc_pkg::PMC_MODE_NCCM;
	endfunction : rail_mode

	function automatic logic [2:0] phase_mask(
		input pmc_pkg::pmc_cfg_t  cfg,
		input pmc_pkg::pmc_mode_t mode
	);
		if (mode == pmc_pkg::PMC_MODE_OFF)
			return 3'h0;
		else if (mode != pmc_pkg::PMC_MODE_NCCM)
			return 3'h1;
		else if (cfg == pmc_pkg::PMC_CFG_3P)
			return 3'h7;
		else
			return 3'h3;
	endfunction : phase_mask

	logic       slew_tick;
	logic [1:0] mode_busy;

	always_comb begin
		pmc_pkg::pmc_zc_in_t zc;
		pmc_pkg::pmc_mode_t  mode;
		logic [7:0]          mon;
		logic                kill;
		zc = '0;
		mode = pmc_pkg::PMC_MODE_OFF;
		mon = 8'h00;
		kill = 1'b0;
		mode_busy = 2'h0;
		s_d = s_q;
		s_d.rdata = 16'h0000;
		slew_tick = (s_q.slew_cnt + 16'h0001) >= s_q.slew_div;
		s_d.slew_cnt = slew_tick ? 16'h0000 : s_q.slew_cnt + 16'h0001;

		// Straps are read only once so a noisy pin cannot reshape rails
		if (!s_q.latched) begin
			s_d.latched = 1'b1;
			s_d.rail[pmc_pkg::CORE].cfg = core_strap(core_phase1_sense,
				core_phase2_sense, core_phase3_sense);
			s_d.rail[pmc_pkg::AUX].cfg = aux_strap(aux_rail_phase1_sense,
				aux_rail_phase2_sense);
		end

		// Mid-pulse changes would truncate a phase
		if (cycle_start)
			s_d.ps = {power_state_low1_n, power_state_low0_n};

		for (int r = 0; r < 2; r++) begin
			zc = (r == pmc_pkg::CORE) ? core_zc : aux_zc;
			mon = (r == pmc_pkg::CORE) ? core_current_monitor
				: aux_rail_current_monitor;
			mode_busy[r] = s_q.rail[r].decay != 8'h00;
			mode = rail_mode(s_q.rail[r].cfg, s_q.ps, mode_busy[r]);
			s_d.rail[r].out.phase_en = phase_mask(s_q.rail[r].cfg, mode);
			s_d.rail[r].out.continuous_conduction =
				mode == pmc_pkg::PMC_MODE_1CCM
				|| mode == pmc_pkg::PMC_MODE_NCCM;
			s_d.rail[r].out.diode_emulation =
				mode == pmc_pkg::PMC_MODE_1DE;
			s_d.rail[r].out.overcurrent = mon >= pmc_pkg::OC_LIMIT;

			// Up moves slew; down moves let the load discharge the rail
			if (s_q.rail[r].tgt > s_q.rail[r].out.vref) begin
				if (slew_tick)
					s_d.rail[r].out.vref = s_q.rail[r].out.vref + 8'h01;
			end else if (s_q.rail[r].tgt < s_q.rail[r].out.vref) begin
				s_d.rail[r].out.vref = s_q.rail[r].tgt;
				s_d.rail[r].decay = pmc_pkg::DECAY_CYC;
			end else if (mode_busy[r]) begin
				s_d.rail[r].decay = s_q.rail[r].decay - 8'h01;
			end

			kill = mode == pmc_pkg::PMC_MODE_1DE && zc.ls_on && zc.zc_cmp;
			s_d.rail[r].out.ls_off = kill;
			if (kill && !s_q.rail[r].out.ls_off) begin
				s_d.rail[r].watch = 1'b1;
				s_d.rail[r].dcnt = 4'h0;
				s_d.rail[r].spike = 1'b0;
			end else if (s_q.rail[r].watch) begin
				if (zc.body_diode && s_q.rail[r].dcnt != 4'hf)
					s_d.rail[r].dcnt = s_q.rail[r].dcnt + 4'h1;
				if (zc.reverse_spike)
					s_d.rail[r].spike = 1'b1;
				// Window closes at the next low-side pulse
				if (zc.ls_on) begin
					s_d.rail[r].watch = 1'b0;
					if ((s_q.rail[r].spike
						|| s_q.rail[r].dcnt < pmc_pkg::DIODE_CYC)
						&& s_q.rail[r].out.zc_thr != 8'hff)
						s_d.rail[r].out.zc_thr =
							s_q.rail[r].out.zc_thr + 8'h01;
					else if (s_q.rail[r].dcnt > pmc_pkg::DIODE_CYC
						&& s_q.rail[r].out.zc_thr != 8'h00)
						s_d.rail[r].out.zc_thr =
							s_q.rail[r].out.zc_thr - 8'h01;
				end
			end
		end

		// Compensator switch exists only with a two-phase core strap
		if (s_q.rail[pmc_pkg::CORE].cfg == pmc_pkg::PMC_CFG_2P) begin
			s_d.comp_sw = s_q.rail[pmc_pkg::CORE].out.phase_en == 3'h3;
			s_d.comp_oe = !s_d.comp_sw;
		end else begin
			s_d.comp_sw = 1'b0;
			s_d.comp_oe = 1'b0;
		end

		if (bus_req.wr) begin
			if (bus_req.addr == pmc_pkg::REG_CORE_VID)
				s_d.rail[pmc_pkg::CORE].tgt = bus_req.wdata[7:0];
			else if (bus_req.addr == pmc_pkg::REG_AUX_VID)
				s_d.rail[pmc_pkg::AUX].tgt = bus_req.wdata[7:0];
			else if (bus_req.addr == pmc_pkg::REG_SLEW_DIV)
				s_d.slew_div = bus_req.wdata;
		end
		if (bus_req.rd) begin
			if (bus_req.addr == pmc_pkg::REG_CORE_VID)
				s_d.rdata = {8'h00, s_q.rail[pmc_pkg::CORE].tgt};
			else if (bus_req.addr == pmc_pkg::REG_AUX_VID)
				s_d.rdata = {8'h00, s_q.rail[pmc_pkg::AUX].tgt};
			else if (bus_req.addr == pmc_pkg::REG_SLEW_DIV)
				s_d.rdata = s_q.slew_div;
			else if (bus_req.addr == pmc_pkg::REG_STATUS)
				s_d.rdata = {5'h00, s_q.comp_sw,
					s_q.rail[pmc_pkg::AUX].out.overcurrent,
					s_q.rail[pmc_pkg::CORE].out.overcurrent,
					s_q.ps, s_q.rail[pmc_pkg::AUX].cfg,
					s_q.rail[pmc_pkg::CORE].cfg, mode_busy};
			else if (bus_req.addr == pmc_pkg::REG_ZC_THR)
				s_d.rdata = {s_q.rail[pmc_pkg::AUX].out.zc_thr,
					s_q.rail[pmc_pkg::CORE].out.zc_thr};
			else if (bus_req.addr == pmc_pkg::REG_VREF)
				s_d.rdata = {s_q.rail[pmc_pkg::AUX].out.vref,
					s_q.rail[pmc_pkg::CORE].out.vref};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_q <= '0;
			s_q.ps <= 2'h3;
			s_q.slew_div <= pmc_pkg::SLEW_DIV_RST;
			for (int r = 0; r < 2; r++) begin
				s_q.rail[r].tgt <= pmc_pkg::VID_RST;
				s_q.rail[r].out.vref <= pmc_pkg::VID_RST;
				s_q.rail[r].out.zc_thr <= pmc_pkg::ZC_THR_RST;
			end
		end else begin
			s_q <= s_d;
		end
	end

	assign rd_data_q = s_q.rdata;
	assign core_out_q = s_q.rail[pmc_pkg::CORE].out;
	assign aux_out_q = s_q.rail[pmc_pkg::AUX].out;
	assign comp_switch_closed_q = s_q.comp_sw;
	assign aux_comp_cap_node_oe_q = s_q.comp_oe;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	property p_core_three_ccm;
		s_q.rail[0].cfg == pmc_pkg::PMC_CFG_3P && s_q.ps == 2'h3
			&& s_q.rail[0].decay == 8'h00
		|=> core_out_q.phase_en == 3'h7 && core_out_q.continuous_conduction;
	endproperty
	a_core_three_ccm: assert property (p_core_three_ccm)
		else $error("three-phase core not in full CONTINUOUS_CONDUCTION");

	property p_core_two_phase;
		s_q.rail[0].cfg == pmc_pkg::PMC_CFG_2P |=> !core_out_q.phase_en[2];
	endproperty
	a_core_two_phase: assert property (p_core_two_phase)
		else $error("phase three active in two-phase core");

	property p_core_one_phase;
		s_q.rail[0].cfg == pmc_pkg::PMC_CFG_1P
		|=> core_out_q.phase_en[2:1] == 2'h0;
	endproperty
	a_core_one_phase: assert property (p_core_one_phase)
		else $error("extra phase active in one-phase core");

	property p_shed_to_de;
		s_q.rail[0].cfg != pmc_pkg::PMC_CFG_OFF && !s_q.ps[0]
		|=> core_out_q.phase_en == 3'h1 && core_out_q.diode_emulation;
	endproperty
	a_shed_to_de: assert property (p_shed_to_de)
		else $error("core not single-phase DE with first bit low");

	property p_disabled;
		s_q.latched && s_q.rail[1].cfg == pmc_pkg::PMC_CFG_OFF
		|=> (aux_out_q.phase_en == 3'h0) [*2];
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("disabled aux rail drives a phase");

	property p_oc_fixed;
		s_q.latched |=> core_out_q.overcurrent
			== ($past(core_current_monitor) >= pmc_pkg::OC_LIMIT);
	endproperty
	a_oc_fixed: assert property (p_oc_fixed)
		else $error("core overcurrent flag wrong");

	property p_down_jump;
		s_q.rail[0].tgt < s_q.rail[0].out.vref
		|=> core_out_q.vref == $past(s_q.rail[0].tgt)
			&& s_q.rail[0].decay == pmc_pkg::DECAY_CYC;
	endproperty
	a_down_jump: assert property (p_down_jump)
		else $error("downward change not released to load");

	property p_switch_track;
		comp_switch_closed_q |-> !aux_comp_cap_node_oe_q;
	endproperty
	a_switch_track: assert property (p_switch_track)
		else $error("aux comp node driven while switch closed");

	property p_switch_open_single;
		s_q.rail[0].cfg == pmc_pkg::PMC_CFG_2P
			&& s_q.rail[0].out.phase_en == 3'h1
		|=> !comp_switch_closed_q && aux_comp_cap_node_oe_q;
	endproperty
	a_switch_open_single: assert property (p_switch_open_single)
		else $error("comp switch not open in single phase");

	property p_ps_boundary;
		s_q.latched && !cycle_start |=> $stable(s_q.ps);
	endproperty
	a_ps_boundary: assert property (p_ps_boundary)
		else $error("power-state applied off the cycle boundary");

	property p_core_off;
		s_q.latched && s_q.rail[0].cfg == pmc_pkg::PMC_CFG_OFF
		|=> core_out_q.phase_en == 3'h0 && !core_out_q.ls_off
			&& !core_out_q.continuous_conduction
			&& !core_out_q.diode_emulation;
	endproperty
	a_core_off: assert property (p_core_off)
		else $error("disabled core rail still active");

	property p_aux_two_ccm;
		s_q.rail[1].cfg == pmc_pkg::PMC_CFG_2P && s_q.ps == 2'h3
			&& s_q.rail[1].decay == 8'h00
		|=> aux_out_q.phase_en == 3'h3 && aux_out_q.continuous_conduction;
	endproperty
	a_aux_two_ccm: assert property (p_aux_two_ccm)
		else $error("two-phase aux rail not in continuous conduction");

	property p_aux_one_phase;
		s_q.rail[1].cfg == pmc_pkg::PMC_CFG_1P
		|=> aux_out_q.phase_en[2:1] == 2'h0;
	endproperty
	a_aux_one_phase: assert property (p_aux_one_phase)
		else $error("extra phase active in one-phase aux rail");

	property p_aux_oc_fixed;
		s_q.latched |=> aux_out_q.overcurrent
			== ($past(aux_rail_current_monitor) >= pmc_pkg::OC_LIMIT);
	endproperty
	a_aux_oc_fixed: assert property (p_aux_oc_fixed)
		else $error("aux overcurrent flag wrong");

	property p_up_step;
		s_q.rail[0].tgt > s_q.rail[0].out.vref
		|=> core_out_q.vref
			== $past(s_q.rail[0].out.vref) + {7'h00, $past(slew_tick)};
	endproperty
	a_up_step: assert property (p_up_step)
		else $error("core reference not ramping one code per tick");

	property p_cut_at_zero;
		s_q.rail[0].cfg != pmc_pkg::PMC_CFG_OFF && s_q.ps != 2'h3
			&& core_zc.ls_on && core_zc.zc_cmp
		|=> core_out_q.ls_off;
	endproperty
	a_cut_at_zero: assert property (p_cut_at_zero)
		else $error("low side not cut at zero crossing");

	property p_thr_hold;
		!(s_q.rail[0].watch && core_zc.ls_on)
		|=> $stable(core_out_q.zc_thr);
	endproperty
	a_thr_hold: assert property (p_thr_hold)
		else $error("core zero-cross threshold moved outside a window");

	property p_switch_two;
		s_q.rail[0].cfg == pmc_pkg::PMC_CFG_2P
			&& s_q.rail[0].out.phase_en == 3'h3
		|=> comp_switch_closed_q && !aux_comp_cap_node_oe_q;
	endproperty
	a_switch_two: assert property (p_switch_two)
		else $error("comp switch not closed in two-phase mode");

	c_shed: cover property (core_out_q.phase_en == 3'h7
		##[1:200] core_out_q.phase_en == 3'h1);
	c_kill: cover property (core_out_q.ls_off ##[1:50] core_zc.ls_on);
	c_ramp: cover property (slew_tick && s_q.rail[1].tgt > aux_out_q.vref);

endmodule : pmc_phase_mode_controller

// ### src/pmc_pkg.sv
// Types and constants of the phase and mode controller
package pmc_pkg;

	// Gray order: off, one phase, two phase, three phase
	typedef enum logic [1:0] {
		PMC_CFG_OFF = 2'h0,
		PMC_CFG_1P  = 2'h1,
		PMC_CFG_2P  = 2'h3,
		PMC_CFG_3P  = 2'h2
	} pmc_cfg_t;

	// Gray order: off, single DE, single CONTINUOUS_CONDUCTION, multi CONTINUOUS_CONDUCTION
	typedef enum logic [1:0] {
		PMC_MODE_OFF  = 2'h0,
		PMC_MODE_1DE  = 2'h1,
		PMC_MODE_1CCM = 2'h3,
		PMC_MODE_NCCM = 2'h2
	} pmc_mode_t;

	localparam int CORE = 0;
	localparam int AUX  = 1;

	localparam logic [3:0] REG_CORE_VID = 4'h0;
	localparam logic [3:0] REG_AUX_VID  = 4'h1;
	localparam logic [3:0] REG_SLEW_DIV = 4'h2;
	localparam logic [3:0] REG_STATUS   = 4'h3;
	localparam logic [3:0] REG_ZC_THR   = 4'h4;
	localparam logic [3:0] REG_VREF     = 4'h5;

	localparam logic [7:0]  VID_RST      = 8'h00;
	localparam logic [7:0]  ZC_THR_RST   = 8'h80;
	// Default ramp: one reference code per 125 cycles
	localparam logic [15:0] SLEW_DIV_RST = 16'h007d;
	// 1.5 V on an 8-bit monitor scale of 2.0 V
	localparam logic [7:0]  OC_LIMIT     = 8'hc0;

	localparam int CLK_MHZ       = 200;
	localparam int DIODE_NS      = 40;
	localparam int DECAY_NS      = 1000;
	localparam logic [3:0] DIODE_CYC =
		4'((DIODE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] DECAY_CYC =
		8'((DECAY_NS * CLK_MHZ) / 1000);

	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} pmc_bus_req_t;

	// Low-side timing feedback of the emulating phase
	typedef struct packed {
		logic ls_on;
		logic zc_cmp;
		logic body_diode;
		logic reverse_spike;
	} pmc_zc_in_t;

	typedef struct packed {
		logic [2:0] phase_en;
		logic       continuous_conduction;
		logic       diode_emulation;
		logic       ls_off;
		logic       overcurrent;
		logic [7:0] vref;
		logic [7:0] zc_thr;
	} pmc_rail_out_t;

	typedef struct packed {
		pmc_cfg_t      cfg;
		logic [7:0]    tgt;
		logic [7:0]    decay;
		logic          watch;
		logic [3:0]    dcnt;
		logic          spike;
		pmc_rail_out_t out;
	} pmc_rail_st_t;

	typedef struct packed {
		logic               latched;
		logic [1:0]         ps;
		logic [15:0]        slew_div;
		logic [15:0]        slew_cnt;
		pmc_rail_st_t [1:0] rail;
		logic               comp_sw;
		logic               comp_oe;
		logic [15:0]        rdata;
	} pmc_state_t;

endpackage : pmc_pkg
